// ### core/tspc_pkg.sv
// *****************************************************************
// Shared constants and types of the trap status and priority block
// *****************************************************************
package tspc_pkg;

	// *************************************************************
	// Register byte addresses on the AXI4-Lite slave
	// *************************************************************
	localparam logic [7:0] ADDR_CORE_CONTROL = 8'h00; // Core control.
	localparam logic [7:0] ADDR_TRAP_CONTROL = 8'h04; // Trap control one.
	localparam logic [7:0] ADDR_CPU_STATUS   = 8'h08; // Priority lower bits.

	// *************************************************************
	// Field positions
	// *************************************************************
	localparam int POS_PRIORITY_UPPER = 3;  // In core control.
	localparam int POS_PRIORITY_LO    = 5;  // Lowest of three bits.
	localparam int POS_NESTING_DIS    = 15; // In trap control.
	localparam int POS_ACC_A_TE       = 10; // Acc A overflow enable.
	localparam int POS_ACC_B_TE       = 9;  // Acc B overflow enable.
	localparam int POS_CAT_TE         = 8;  // Catastrophic enable.
	localparam int POS_FLAGS_HI       = 11; // Bits 14..11 hold flags.
	localparam int POS_FLAGS_LO       = 1;  // Bits 7..1 hold flags.

	// *************************************************************
	// Counts, widths and reset values
	// *************************************************************
	localparam int          NUM_FLAGS       = 11;   // Sticky trap flags.
	localparam int          PRIORITY_HIGHEST_LOWER = 7; // Level seven.
	localparam logic [10:0] FLAGS_RESET     = 11'h000; // Flags clear.
	localparam logic [2:0]  PRIORITY_LO_RESET = 3'h0; // Level zero.
	localparam logic        PRIORITY_UP_RESET = 1'b0; // Level seven or less.
	localparam logic        NESTING_RESET   = 1'b0;   // Nesting allowed.
	localparam logic        ENABLE_RESET    = 1'b0;   // Traps disabled.
	localparam logic [1:0]  RESP_OKAY       = 2'h0;   // AXI OKAY.
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;   // AXI SLVERR.

	// *************************************************************
	// Flag vector indices, highest bit of the register first
	// *************************************************************
	localparam int FLG_ACC_A_OVF = 10; // Register bit 14.
	localparam int FLG_ACC_B_OVF = 9;  // Register bit 13.
	localparam int FLG_ACC_A_CAT = 8;  // Register bit 12.
	localparam int FLG_ACC_B_CAT = 7;  // Register bit 11.
	localparam int FLG_SHIFT     = 6;  // Register bit 7.
	localparam int FLG_DIVIDE    = 5;  // Register bit 6.
	localparam int FLG_DMA       = 4;  // Register bit 5.
	localparam int FLG_MATH      = 3;  // Register bit 4.
	localparam int FLG_ADDRESS   = 2;  // Register bit 3.
	localparam int FLG_STACK     = 1;  // Register bit 2.
	localparam int FLG_OSC       = 0;  // Register bit 1.

	// Register selected by an address.
	typedef enum {
		TSPC_SEL_CORE,
		TSPC_SEL_TRAP,
		TSPC_SEL_STATUS,
		TSPC_SEL_NONE
	} tspc_sel_type;

	// Trap source events from the execution units, one-cycle pulses.
	typedef struct packed {
		logic acc_a_overflow;
		logic acc_b_overflow;
		logic acc_a_catastrophic;
		logic acc_b_catastrophic;
		logic invalid_shift;
		logic divide_by_zero;
		logic dma_error;
		logic address_error;
		logic stack_error;
		logic osc_failure;
	} tspc_event_type;

	// Trap requests passed on to the exception sequencer.
	typedef struct packed {
		logic osc_failure;
		logic address_error;
		logic stack_error;
		logic math_error;
		logic dma_error;
	} tspc_trap_type;

endpackage : tspc_pkg

// ### core/tspc_flag_bank.sv
`timescale 1ns/1ps
// *****************************************************************
// Bank of sticky flags, set by hardware and loaded by software
// *****************************************************************
module tspc_flag_bank #(
	parameter int          WIDTH      = 11,
	parameter logic [10:0] RESET_BITS = 11'h000
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] set_bits,
	input  wire logic             load_en,
	input  wire logic [WIDTH-1:0] load_bits,
	output logic      [WIDTH-1:0] flags
);
	import tspc_pkg::*;

	// All state of the bank.
	typedef struct packed {
		logic [WIDTH-1:0] q;
	} tspc_bank_type;

	tspc_bank_type state;      // Registered flags.
	tspc_bank_type next_state; // Value for the next edge.

	// Each bit keeps its value, takes a software load, and is forced
	// high by its event; the event wins so a trap that lands in the
	// cycle of a clearing write is never lost.
	always_comb begin
		next_state = state;
		for (int i = 0; i < WIDTH; i++) begin
			if (set_bits[i]) begin
				next_state.q[i] = 1'b1;
			end else if (load_en) begin
				next_state.q[i] = load_bits[i];
			end
		end
	end

	// Synchronous reset clears every flag.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state.q <= RESET_BITS[WIDTH-1:0];
		end else begin
			state <= next_state;
		end
	end

	assign flags = state.q;

endmodule : tspc_flag_bank

// ### core/tspc_top.sv
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module tspc_top (
	input  wire logic                     ref_clk,
	input  wire logic                     rst_n,
	// AXI4-Lite write address channel.
	input  wire logic [7:0]               s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	// AXI4-Lite write data channel.
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	// AXI4-Lite write response channel.
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	// AXI4-Lite read address channel.
	input  wire logic [7:0]               s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	// AXI4-Lite read data channel.
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	// Trap sources and priority load from the core.
	input  wire tspc_pkg::tspc_event_type trap_events,
	input  wire logic                     core_priority_load,
	input  wire logic [3:0]               core_priority_value,
	// Results toward the interrupt controller and sequencer.
	output tspc_pkg::tspc_trap_type       trap_requests,
	output logic [3:0]                    priority_level,
	output logic                          user_irq_blocked,
	output logic                          nesting_allowed
);
	import tspc_pkg::*;

	// *************************************************************
	// State
	// *************************************************************

	// All registered state of the block outside the flag bank.
	typedef struct packed {
		logic                   aw_held;      // Write address taken.
		logic [7:0]             aw_addr;      // Held write address.
		logic                   w_held;       // Write data taken.
		logic [31:0]            w_data;       // Held write data.
		logic [3:0]             w_strb;       // Held byte strobes.
		logic                   awready;      // Address channel ready.
		logic                   wready;       // Data channel ready.
		logic                   bvalid;       // Response pending.
		logic [1:0]             bresp;        // Response code.
		logic                   arready;      // Read address ready.
		logic                   rvalid;       // Read data pending.
		logic [31:0]            rdata;        // Read data.
		logic [1:0]             rresp;        // Read response code.
		logic                   priority_upper_bit;  // Level above 7.
		logic [2:0]             priority_lower_bits; // Low level bits.
		logic                   nesting_disable;     // No nesting.
		logic                   acc_a_overflow_trap_enable;
		logic                   acc_b_overflow_trap_enable;
		logic                   catastrophic_trap_enable;
		tspc_trap_type          traps;        // Registered requests.
		logic [3:0]             level;        // Registered level.
		logic                   blocked;      // User irqs blocked.
		logic                   nest_ok;      // Nesting allowed.
	} tspc_state_type;

	tspc_state_type        state;      // Current state.
	tspc_state_type        next_state; // State at the next edge.
	logic [NUM_FLAGS-1:0]  flags;      // Sticky trap flags.
	logic [NUM_FLAGS-1:0]  flag_set;   // Hardware set of each flag.
	logic                  flag_load;  // Software writes trap control.
	logic [NUM_FLAGS-1:0]  flag_data;  // Flag values being written.
	logic                  wr_fire;    // Write performed this cycle.
	tspc_sel_type          wr_sel;     // Register being written.
	logic [15:0]           wr_low;     // Low half of write data.
	logic                  acc_a_trap; // Qualified accumulator A trap.
	logic                  acc_b_trap; // Qualified accumulator B trap.
	logic                  cat_trap;   // Qualified catastrophic trap.
	logic                  math_trap;  // Any math error trap.

	// *************************************************************
	// Helpers
	// *************************************************************

	// Maps a byte address onto a register; read and write share it
	// so both sides always agree on the map.
	function automatic tspc_sel_type decode_sel(input logic [7:0] addr);
		case (addr)
			ADDR_CORE_CONTROL: begin
				decode_sel = TSPC_SEL_CORE;
			end
			ADDR_TRAP_CONTROL: begin
				decode_sel = TSPC_SEL_TRAP;
			end
			ADDR_CPU_STATUS: begin
				decode_sel = TSPC_SEL_STATUS;
			end
			default: begin
				decode_sel = TSPC_SEL_NONE;
			end
		endcase
	endfunction : decode_sel

	// *************************************************************
	// Trap qualification
	// *************************************************************

	// Overflow events become traps only under their enables, so a
	// disabled source leaves both its flag and the request quiet.
	always_comb begin
		acc_a_trap = trap_events.acc_a_overflow &
			state.acc_a_overflow_trap_enable;
		acc_b_trap = trap_events.acc_b_overflow &
			state.acc_b_overflow_trap_enable;
		cat_trap = (trap_events.acc_a_catastrophic |
			trap_events.acc_b_catastrophic) &
			state.catastrophic_trap_enable;
		math_trap = acc_a_trap | acc_b_trap | cat_trap |
			trap_events.invalid_shift | trap_events.divide_by_zero;
	end

	// Sets for each sticky flag, in flag vector order.
	always_comb begin
		flag_set                = '0;
		flag_set[FLG_ACC_A_OVF] = acc_a_trap;
		flag_set[FLG_ACC_B_OVF] = acc_b_trap;
		flag_set[FLG_ACC_A_CAT] = trap_events.acc_a_catastrophic &
			state.catastrophic_trap_enable;
		flag_set[FLG_ACC_B_CAT] = trap_events.acc_b_catastrophic &
			state.catastrophic_trap_enable;
		flag_set[FLG_SHIFT]     = trap_events.invalid_shift;
		flag_set[FLG_DIVIDE]    = trap_events.divide_by_zero;
		flag_set[FLG_DMA]       = trap_events.dma_error;
		flag_set[FLG_MATH]      = math_trap;
		flag_set[FLG_ADDRESS]   = trap_events.address_error;
		flag_set[FLG_STACK]     = trap_events.stack_error;
		flag_set[FLG_OSC]       = trap_events.osc_failure;
	end

	// *************************************************************
	// Write path decode
	// *************************************************************

	// A write is done once both address and data are held and the
	// previous response has gone.
	always_comb begin
		wr_fire = state.aw_held & state.w_held & ~state.bvalid;
		wr_sel  = decode_sel(state.aw_addr);
		wr_low  = state.w_data[15:0];
		// Every write to trap control reloads the flags, whatever its strobes;
		// a partial write loads the untouched byte with its own value.
		flag_load = wr_fire && (wr_sel == TSPC_SEL_TRAP);
		flag_data = flags;
		if (state.w_strb[1]) begin
			flag_data[FLG_ACC_A_OVF:FLG_ACC_B_CAT] =
				wr_low[14:POS_FLAGS_HI];
		end
		if (state.w_strb[0]) begin
			flag_data[FLG_SHIFT:FLG_OSC] = wr_low[7:POS_FLAGS_LO];
		end
	end

	// The sticky flags live in their own bank; hardware sets win.
	tspc_flag_bank #(
		.WIDTH      (NUM_FLAGS),
		.RESET_BITS (FLAGS_RESET)
	) u_flags (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.set_bits  (flag_set),
		.load_en   (flag_load),
		.load_bits (flag_data),
		.flags     (flags)
	);

	// *************************************************************
	// Next state
	// *************************************************************

	// Bus handshakes, register writes, priority and trap outputs.
	always_comb begin
		next_state = state;

		// Address and data are taken independently in any order.
		if (s_axi_awvalid && state.awready) begin
			next_state.aw_held = 1'b1;
			next_state.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && state.wready) begin
			next_state.w_held = 1'b1;
			next_state.w_data = s_axi_wdata;
			next_state.w_strb = s_axi_wstrb;
		end

		// Perform the held write and raise the response.
		if (wr_fire) begin
			next_state.aw_held = 1'b0;
			next_state.w_held  = 1'b0;
			next_state.bvalid  = 1'b1;
			next_state.bresp   = RESP_OKAY;
			case (wr_sel)
				TSPC_SEL_CORE: begin
					// The upper bit is clear-only: a zero clears it
					// and a one is ignored, so traps stay unmaskable.
					if (state.w_strb[0] &&
						!wr_low[POS_PRIORITY_UPPER]) begin
						next_state.priority_upper_bit = 1'b0;
					end
				end
				TSPC_SEL_TRAP: begin
					// Bit zero is not stored anywhere.
					if (state.w_strb[1]) begin
						next_state.nesting_disable =
							wr_low[POS_NESTING_DIS];
						next_state.acc_a_overflow_trap_enable =
							wr_low[POS_ACC_A_TE];
						next_state.acc_b_overflow_trap_enable =
							wr_low[POS_ACC_B_TE];
						next_state.catastrophic_trap_enable =
							wr_low[POS_CAT_TE];
					end
				end
				TSPC_SEL_STATUS: begin
					// Lower bits ignore software writes while nesting is disabled.
					if (state.w_strb[0] && !state.nesting_disable) begin
						next_state.priority_lower_bits =
							wr_low[POS_PRIORITY_LO+2:POS_PRIORITY_LO];
					end
				end
				default: begin
					next_state.bresp = RESP_SLVERR;
				end
			endcase
		end

		// The response leaves when the master takes it.
		if (state.bvalid && s_axi_bready) begin
			next_state.bvalid = 1'b0;
		end

		// The core loads the whole level on trap entry and return;
		// this is the only path that can raise the upper bit, and it
		// wins over a software write in the same cycle.
		if (core_priority_load) begin
			next_state.priority_upper_bit  = core_priority_value[3];
			next_state.priority_lower_bits = core_priority_value[2:0];
		end

		// Readiness follows the updated holding state at the same edge.
		next_state.awready = ~next_state.aw_held & ~next_state.bvalid;
		next_state.wready  = ~next_state.w_held & ~next_state.bvalid;

		// Read: answer one edge after the address is taken.
		if (s_axi_arvalid && state.arready) begin
			next_state.arready = 1'b0;
			next_state.rvalid  = 1'b1;
			next_state.rresp   = RESP_OKAY;
			next_state.rdata   = '0;
			case (decode_sel(s_axi_araddr))
				TSPC_SEL_CORE: begin
					next_state.rdata[POS_PRIORITY_UPPER] =
						state.priority_upper_bit;
				end
				TSPC_SEL_TRAP: begin
					next_state.rdata[POS_NESTING_DIS] =
						state.nesting_disable;
					next_state.rdata[14:POS_FLAGS_HI] =
						flags[FLG_ACC_A_OVF:FLG_ACC_B_CAT];
					next_state.rdata[POS_ACC_A_TE] =
						state.acc_a_overflow_trap_enable;
					next_state.rdata[POS_ACC_B_TE] =
						state.acc_b_overflow_trap_enable;
					next_state.rdata[POS_CAT_TE] =
						state.catastrophic_trap_enable;
					next_state.rdata[7:POS_FLAGS_LO] =
						flags[FLG_SHIFT:FLG_OSC];
					next_state.rdata[0] = 1'b0;
				end
				TSPC_SEL_STATUS: begin
					next_state.rdata[POS_PRIORITY_LO+2:POS_PRIORITY_LO] =
						state.priority_lower_bits;
				end
				default: begin
					next_state.rresp = RESP_SLVERR;
				end
			endcase
		end else if (state.rvalid && s_axi_rready) begin
			next_state.rvalid  = 1'b0;
			next_state.arready = 1'b1;
		end

		// Trap requests are registered one-cycle pulses.
		next_state.traps.osc_failure   = trap_events.osc_failure;
		next_state.traps.address_error = trap_events.address_error;
		next_state.traps.stack_error   = trap_events.stack_error;
		next_state.traps.math_error    = math_trap;
		next_state.traps.dma_error     = trap_events.dma_error;

		// Level outputs follow the updated priority fields.
		next_state.level = {next_state.priority_upper_bit,
			next_state.priority_lower_bits};
		next_state.blocked = next_state.priority_upper_bit ||
			(next_state.priority_lower_bits ==
			3'(PRIORITY_HIGHEST_LOWER));
		next_state.nest_ok = ~next_state.nesting_disable;
	end

	// *************************************************************
	// Registers
	// *************************************************************

	// Synchronous reset gives every field its power-on value.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state                            <= '0;
			state.awready                    <= 1'b1;
			state.wready                     <= 1'b1;
			state.arready                    <= 1'b1;
			state.priority_upper_bit         <= PRIORITY_UP_RESET;
			state.priority_lower_bits        <= PRIORITY_LO_RESET;
			state.nesting_disable            <= NESTING_RESET;
			state.acc_a_overflow_trap_enable <= ENABLE_RESET;
			state.acc_b_overflow_trap_enable <= ENABLE_RESET;
			state.catastrophic_trap_enable   <= ENABLE_RESET;
			state.nest_ok                    <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	// *************************************************************
	// Outputs, all straight from flip-flops
	// *************************************************************
	assign s_axi_awready    = state.awready;
	assign s_axi_wready     = state.wready;
	assign s_axi_bvalid     = state.bvalid;
	assign s_axi_bresp      = state.bresp;
	assign s_axi_arready    = state.arready;
	assign s_axi_rvalid     = state.rvalid;
	assign s_axi_rdata      = state.rdata;
	assign s_axi_rresp      = state.rresp;
	assign trap_requests    = state.traps;
	assign priority_level   = state.level;
	assign user_irq_blocked = state.blocked;
	assign nesting_allowed  = state.nest_ok;

endmodule : tspc_top

// ### test/tspc_src_model.sv
`timescale 1ns/1ps
// *****************************************************************
// Trap source model: the execution units that raise trap events
// *****************************************************************
module tspc_src_model (
	input  wire logic             ref_clk,
	input  wire logic             go,
	input  wire logic [3:0]       idx,
	output tspc_pkg::tspc_event_type ev
);
	import tspc_pkg::*;
	// One source fires for exactly one cycle, like the real units.
	always @(posedge ref_clk) begin
		ev <= go ? tspc_event_type'(10'h001 << idx) : '0;
	end
endmodule : tspc_src_model

// ### test/tspc_sva.sv
`timescale 1ns/1ps
// *****************************************************************
// Port checker of the trap status and priority block
// *****************************************************************
module tspc_sva (
	input wire logic                     ref_clk,
	input wire logic                     rst_n,
	input wire logic                     s_axi_awvalid,
	input wire logic                     s_axi_awready,
	input wire logic                     s_axi_wvalid,
	input wire logic                     s_axi_wready,
	input wire logic                     s_axi_bvalid,
	input wire logic                     s_axi_bready,
	input wire logic                     s_axi_arvalid,
	input wire logic                     s_axi_arready,
	input wire logic                     s_axi_rvalid,
	input wire logic                     s_axi_rready,
	input wire tspc_pkg::tspc_event_type trap_events,
	input wire logic                     core_priority_load,
	input wire logic [3:0]               core_priority_value,
	input wire tspc_pkg::tspc_trap_type  trap_requests,
	input wire logic [3:0]               priority_level,
	input wire logic                     user_irq_blocked
);
	import tspc_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Both write channels taken at one edge, and a read taken.
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_answer:
		assert property (wr_taken |-> ##2 s_axi_bvalid) else $error("no bvalid");
	a_read_answer:
		assert property (rd_taken |=> s_axi_rvalid) else $error("no rvalid");
	a_bvalid_hold:
		assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	a_rvalid_hold:
		assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("rvalid dropped");
	a_block_level:
		assert property (user_irq_blocked ==
			(priority_level[3] || priority_level[2:0] == 3'h7))
		else $error("blocking wrong");
	a_upper_no_set:
		assert property ($rose(priority_level[3]) |->
			$past(core_priority_load) && $past(core_priority_value[3]))
		else $error("upper bit set");
	a_math_req:
		assert property (trap_events.divide_by_zero || trap_events.invalid_shift
			|=> trap_requests.math_error) else $error("no math request");
	a_dma_req:
		assert property (trap_events.dma_error |=> trap_requests.dma_error)
		else $error("no dma request");
	a_addr_req:
		assert property (trap_events.address_error
			|=> trap_requests.address_error) else $error("no addr request");
	a_stack_req:
		assert property (trap_events.stack_error |=> trap_requests.stack_error)
		else $error("no stack request");
	a_osc_req:
		assert property (trap_events.osc_failure |=> trap_requests.osc_failure)
		else $error("no osc request");
endmodule : tspc_sva

// ### test/tb_trap_status_priority_control.sv
`timescale 1ns/1ps
`define CK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
	$display("mismatch at %0t: got %h want %h", $time, a, b); end end
module tb_trap_status_priority_control;
	import tspc_pkg::*;
	logic           ref_clk, rst_n, core_priority_load, ev_go;
	logic [3:0]     core_priority_value, s_axi_wstrb, ev_idx, priority_level;
	logic [7:0]     s_axi_awaddr, s_axi_araddr;
	logic [31:0]    s_axi_wdata, s_axi_rdata, v;
	logic           s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic           s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic           s_axi_arready, s_axi_rvalid, user_irq_blocked;
	logic           nesting_allowed;
	logic [1:0]     s_axi_bresp, s_axi_rresp;
	tspc_event_type trap_events;
	tspc_trap_type  trap_requests;
	int             failures, num_checks, seed;
	tspc_top i_tspc_top (.*);
	tspc_src_model i_tspc_src_model (.ref_clk(ref_clk), .go(ev_go),
		.idx(ev_idx), .ev(trap_events));
	always #4 ref_clk = ~ref_clk;
	// *************************************************************
	// Closing report
	// *************************************************************
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	// One bus transfer; each channel is released at the edge it is taken.
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge ref_clk);
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
		{s_axi_arvalid, s_axi_rready} <= {2{!w}};
		while (n < 100) begin
			@(posedge ref_clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (w ? s_axi_bvalid : s_axi_rvalid) begin
				q = s_axi_rdata;
				r = w ? s_axi_bresp : s_axi_rresp;
				n = 1000;
			end
		end
		if (n != 1000) begin
			failures++;
			give_verdict();
		end
		{s_axi_bready, s_axi_rready} <= 2'b00;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e = RESP_OKAY);
		logic [31:0] q;
		logic [1:0]  r;
		bus(1'b1, a, d, q, r);
		`CK(r, e)
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] x,
		input logic [1:0] e = RESP_OKAY);
		logic [31:0] q;
		logic [1:0]  r;
		bus(1'b0, a, 32'h0, q, r);
		`CK(q, x)
		`CK(r, e)
	endtask : rd
	task automatic pulse(input int i);
		@(posedge ref_clk);
		{ev_go, ev_idx} <= {1'b1, 4'(i)};
		@(posedge ref_clk);
		ev_go <= 1'b0;
	endtask : pulse
	// Register bits expected after one event, source order msb first.
	function automatic logic [15:0] fl(input int i);
		case (i)
			9: fl = 16'h4010;
			8: fl = 16'h2010;
			7: fl = 16'h1010;
			6: fl = 16'h0810;
			5: fl = 16'h0090;
			4: fl = 16'h0050;
			3: fl = 16'h0020;
			2: fl = 16'h0008;
			1: fl = 16'h0004;
			default: fl = 16'h0002;
		endcase
	endfunction : fl
	initial begin
		ref_clk = 1'b0;
		{rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 4'h0;
		{s_axi_arvalid, s_axi_rready, ev_go, core_priority_load} <= 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
		{core_priority_value, ev_idx, s_axi_wstrb} <= 12'h00F;
		{failures, num_checks, seed} = {32'd0, 32'd0, 32'd28};
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(ADDR_CORE_CONTROL, 0);
		rd(ADDR_TRAP_CONTROL, 0);
		rd(ADDR_CPU_STATUS, 0);
		`CK(nesting_allowed, 1'b1)
		$display("test reset done");
		wr(ADDR_TRAP_CONTROL, 32'h700);
		for (int i = 0; i < 10; i++) begin
			pulse(i);
			rd(ADDR_TRAP_CONTROL, 32'h700 | fl(i));
			rd(ADDR_TRAP_CONTROL, 32'h700 | fl(i));
			wr(ADDR_TRAP_CONTROL, 32'h700);
		end
		wr(ADDR_TRAP_CONTROL, 0);
		for (int i = 6; i < 10; i++) pulse(i);
		rd(ADDR_TRAP_CONTROL, 0);
		$display("test events done");
		repeat (8) begin
			v = $random(seed);
			wr(ADDR_TRAP_CONTROL, v);
			rd(ADDR_TRAP_CONTROL, v & 32'hFFFE);
			`CK(nesting_allowed, !v[15])
		end
		wr(ADDR_TRAP_CONTROL, 32'hFFFF);
		rd(ADDR_TRAP_CONTROL, 32'hFFFE);
		wr(ADDR_CPU_STATUS, 32'hE0);
		rd(ADDR_CPU_STATUS, 0);
		wr(ADDR_TRAP_CONTROL, 0);
		// Low byte only: the flags of bits 7..1 load, the upper byte keeps.
		s_axi_wstrb <= 4'h1;
		wr(ADDR_TRAP_CONTROL, 32'hFFFF);
		rd(ADDR_TRAP_CONTROL, 32'hFE);
		s_axi_wstrb <= 4'hF;
		wr(ADDR_CPU_STATUS, 32'hE0);
		rd(ADDR_CPU_STATUS, 32'hE0);
		`CK(priority_level, 4'h7)
		`CK(user_irq_blocked, 1'b1)
		$display("test priority done");
		wr(ADDR_CORE_CONTROL, 32'h8);
		rd(ADDR_CORE_CONTROL, 0);
		@(posedge ref_clk);
		{core_priority_load, core_priority_value} <= 5'h1C;
		@(posedge ref_clk);
		core_priority_load <= 1'b0;
		rd(ADDR_CORE_CONTROL, 32'h8);
		`CK(priority_level, 4'hC)
		`CK(user_irq_blocked, 1'b1)
		wr(ADDR_CORE_CONTROL, 0);
		rd(ADDR_CORE_CONTROL, 0);
		`CK(priority_level, 4'h4)
		`CK(user_irq_blocked, 1'b0)
		wr(8'h0C, 32'h1, RESP_SLVERR);
		rd(8'h0C, 0, RESP_SLVERR);
		$display("test bus done");
		give_verdict();
	end
endmodule : tb_trap_status_priority_control
bind tspc_top tspc_sva i_tspc_sva (.*);
